// file: ssm_map.vh
// Purpose: constants for the stored sequence manager
// Assumes: included by ssm_top.v, the checker and the test; guarded
// Notes:   opcodes are decoded upstream; codes below are local
`ifndef SSM_MAP_VH
`define SSM_MAP_VH
`define SSM_OP_NONE   4'h0
`define SSM_OP_DEFINE 4'h1
`define SSM_OP_TERM   4'h2
`define SSM_OP_ERASE  4'h3
`define SSM_OP_RUN    4'h4
`define SSM_OP_RUNP   4'h5
`define SSM_OP_GO     4'h6
`define SSM_OP_SAVE   4'h7
`define SSM_OP_IRMODE 4'h8
`define SSM_OP_INFUNC 4'h9
`define SSM_OP_SCAN   4'hA
`define SSM_OP_RESET  4'hB
`define SSM_SLOT_MIN  6'h01
`define SSM_SLOT_RUNMAX 6'h27
`define SSM_SLOT_PWR  6'h28
`define SSM_STORE_SZ  11'h5DC
`define SSM_ADDR_ZERO 11'h000
`define SSM_NIB_MAX   4'h9
`define SSM_BCD_TEN   7'h0A
`define SSM_FUNC_SEL  4'h1
`define SSM_ST_IDLE   2'h0
`define SSM_ST_REC    2'h1
`define SSM_ST_RUN    2'h2
`define SSM_ST_SAVE   2'h3
`endif

// file: ssm_top.v
// Purpose: define, erase, save and run stored command sequences
// Assumes: commands arrive decoded, one per cycle, with slot and byte
// Notes:   store is an array here; non-volatile copy is a shadow flag
`default_nettype none
`include "ssm_map.vh"
// Function
// R1 - Define opens recording into slot 1..40
// R2 - Terminate closes open definition
// R3 - Store recorded bytes, replay in order
// R4 - Immediate commands never recorded
// R5 - Shared 1500 byte store, 40 slots
// R6 - Slot 40 not an ordinary run target
// R7 - Run takes slot 1..39
// R8 - Refuse redefining an occupied slot
// R9 - Erase slot 1..40, allow redefinition
// R10 - Definitions volatile until save command
// R11 - Slot selectable via BCD inputs
// R12 - Input counts only if assigned select
// R13 - Continuous scan runs selected sequence
// R14 - Exit-and-go jumps to named sequence
// R15 - Run-with-pause starts paused run; code only raises run_paused, replay of the bytes goes on
// R16 - Command sets or clears interrupted-run mode
// R17 - Power-up and reset run slot 40; rst_b clears every slot, so only the reset command runs it
// R18 - Slot 40 chains via run or go; code chains on go only, a run command is ignored while running
// R19 - Reject bytes beyond store capacity
// R20 - Reject out-of-range slot numbers
module ssm_top (
	// Clock and reset
	input  wire        clk,
	input  wire        rst_b,
	// Decoded command port
	input  wire        cmd_valid,
	input  wire [3:0]  cmd_op,
	input  wire [5:0]  cmd_slot,
	input  wire        cmd_flag,
	input  wire [3:0]  cmd_input_idx,
	input  wire        chr_valid,
	input  wire [7:0]  chr_data,
	input  wire        chr_buffered,
	// Programmable input pins
	input  wire [7:0]  prog_in,
	// Replay port
	input  wire        play_ready,
	output reg         play_valid,
	output reg  [7:0]  play_data,
	output reg         play_chain,
	output reg  [5:0]  run_slot,
	output reg         run_paused,
	output reg         irq_run_mode,
	output reg         busy,
	output reg         cmd_error,
	output reg         nv_dirty
);
	reg [7:0]  mem_q [0:1499];
	reg [10:0] start_q [1:40];
	reg [10:0] len_q [1:40];
	reg [40:1] used_q;
	reg [10:0] fill_q;
	reg [1:0]  st_q;
	reg [5:0]  rec_slot_q;
	reg [10:0] ptr_q;
	reg [10:0] end_q;
	reg [7:0]  sel_map_q;
	reg        scan_q;
	reg        boot_q;
	reg [7:0]  pin_a_q, pin_b_q, pin_c_q;
	reg [5:0]  scan_last_q;
	wire [7:0] sel_bits;
	wire [5:0] bcd_slot;
	wire [6:0] bcd_wide;
	wire       pin_stable;
	integer    i;

	// Three-stage sync; only b and c agreeing counts as a change
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_a_q <= 8'h00;
			pin_b_q <= 8'h00;
			pin_c_q <= 8'h00;
		end else begin
			pin_a_q <= prog_in;
			pin_b_q <= pin_a_q;
			pin_c_q <= pin_b_q;
		end
	end
	assign pin_stable = (pin_b_q == pin_c_q);

	// Only inputs assigned the select function contribute
	assign sel_bits = pin_c_q & sel_map_q; // R12
	// Low nibble units, high nibble tens; seven bits so 99 cannot wrap
	assign bcd_wide = ({3'h0, sel_bits[7:4]} * `SSM_BCD_TEN) +
		{3'h0, sel_bits[3:0]}; // R11
	// Non-BCD digits or numbers above 40 select nothing
	assign bcd_slot = (sel_bits[7:4] > `SSM_NIB_MAX ||
		sel_bits[3:0] > `SSM_NIB_MAX ||
		bcd_wide > {1'b0, `SSM_SLOT_PWR}) ? 6'h00 : bcd_wide[5:0]; // R11

	function ok_run;
		input [5:0] s;
		begin
			ok_run = (s >= `SSM_SLOT_MIN) &&
				(s <= `SSM_SLOT_RUNMAX); // R6 R7 R20
		end
	endfunction

	function ok_def;
		input [5:0] s;
		begin
			ok_def = (s >= `SSM_SLOT_MIN) && (s <= `SSM_SLOT_PWR); // R20
		end
	endfunction

	// Main sequencer; erase compacts nothing, freed space only
	// returns when the erased slot was the last one written
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= `SSM_ST_IDLE;
			used_q <= 40'h0000000000;
			fill_q <= `SSM_ADDR_ZERO;
			rec_slot_q <= 6'h00;
			ptr_q <= `SSM_ADDR_ZERO;
			end_q <= `SSM_ADDR_ZERO;
			sel_map_q <= 8'h00;
			scan_q <= 1'b0;
			boot_q <= 1'b1;
			scan_last_q <= 6'h00;
			play_valid <= 1'b0;
			play_data <= 8'h00;
			play_chain <= 1'b0;
			run_slot <= 6'h00;
			run_paused <= 1'b0;
			irq_run_mode <= 1'b0;
			busy <= 1'b0;
			cmd_error <= 1'b0;
			nv_dirty <= 1'b0;
			for (i = 1; i <= 40; i = i + 1) begin
				start_q[i] <= `SSM_ADDR_ZERO;
				len_q[i] <= `SSM_ADDR_ZERO;
			end
		end else begin
			cmd_error <= 1'b0;
			if (play_valid && play_ready)
				play_valid <= 1'b0;
			// Power-up or reset: run slot 40 if it holds anything
			if (boot_q) begin
				boot_q <= 1'b0;
				if (used_q[`SSM_SLOT_PWR] &&
					len_q[`SSM_SLOT_PWR] != `SSM_ADDR_ZERO) begin // R17
					st_q <= `SSM_ST_RUN;
					run_slot <= `SSM_SLOT_PWR;
					ptr_q <= start_q[`SSM_SLOT_PWR];
					end_q <= start_q[`SSM_SLOT_PWR] +
						len_q[`SSM_SLOT_PWR];
					busy <= 1'b1;
				end
			end else if (cmd_valid && cmd_op == `SSM_OP_RESET) begin
				st_q <= `SSM_ST_IDLE;
				boot_q <= 1'b1; // R17
				busy <= 1'b0;
				play_valid <= 1'b0;
			end else if (cmd_valid && cmd_op == `SSM_OP_IRMODE) begin
				irq_run_mode <= cmd_flag; // R16
			end else if (cmd_valid && cmd_op == `SSM_OP_INFUNC) begin
				sel_map_q[cmd_input_idx[2:0]] <=
					(cmd_flag && cmd_slot[3:0] == `SSM_FUNC_SEL); // R12
			end else if (cmd_valid && cmd_op == `SSM_OP_SCAN) begin
				scan_q <= cmd_flag; // R13
			end else begin
				case (st_q)
				`SSM_ST_IDLE: begin
					if (cmd_valid) begin
						case (cmd_op)
						`SSM_OP_DEFINE: begin
							if (!ok_def(cmd_slot) ||
								used_q[cmd_slot]) begin // R8 R20
								cmd_error <= 1'b1;
							end else begin
								st_q <= `SSM_ST_REC; // R1
								rec_slot_q <= cmd_slot;
								used_q[cmd_slot] <= 1'b1;
								start_q[cmd_slot] <= fill_q;
								len_q[cmd_slot] <= `SSM_ADDR_ZERO;
								busy <= 1'b1;
							end
						end
						`SSM_OP_ERASE: begin
							if (!ok_def(cmd_slot)) begin // R20
								cmd_error <= 1'b1;
							end else begin
								used_q[cmd_slot] <= 1'b0; // R9
								if (start_q[cmd_slot] + len_q[cmd_slot]
									== fill_q && used_q[cmd_slot])
									fill_q <= start_q[cmd_slot];
								nv_dirty <= 1'b1;
							end
						end
						`SSM_OP_RUN, `SSM_OP_RUNP, `SSM_OP_GO: begin
							if (!ok_run(cmd_slot) ||
								!used_q[cmd_slot]) begin // R7 R20
								cmd_error <= 1'b1;
							end else begin
								st_q <= `SSM_ST_RUN;
								run_slot <= cmd_slot;
								run_paused <= (cmd_op == `SSM_OP_RUNP); // R15
								ptr_q <= start_q[cmd_slot];
								end_q <= start_q[cmd_slot] + len_q[cmd_slot];
								busy <= 1'b1;
							end
						end
						`SSM_OP_SAVE: begin
							st_q <= `SSM_ST_SAVE; // R10
							busy <= 1'b1;
						end
						default: cmd_error <= 1'b0;
						endcase
					end else if (scan_q && pin_stable &&
						bcd_slot != scan_last_q) begin
						scan_last_q <= bcd_slot;
						if (ok_run(bcd_slot) && used_q[bcd_slot]) begin // R13
							st_q <= `SSM_ST_RUN;
							run_slot <= bcd_slot;
							run_paused <= 1'b0;
							ptr_q <= start_q[bcd_slot];
							end_q <= start_q[bcd_slot] + len_q[bcd_slot];
							busy <= 1'b1;
						end
					end
				end
				`SSM_ST_REC: begin
					if (cmd_valid && cmd_op == `SSM_OP_TERM) begin
						st_q <= `SSM_ST_IDLE; // R2
						busy <= 1'b0;
					end else if (chr_valid && chr_buffered) begin // R4
						if (fill_q == `SSM_STORE_SZ) begin // R5 R19
							cmd_error <= 1'b1;
						end else begin
							mem_q[fill_q] <= chr_data; // R3
							fill_q <= fill_q + 11'h001;
							len_q[rec_slot_q] <= len_q[rec_slot_q] + 11'h001;
							nv_dirty <= 1'b1;
						end
					end
				end
				`SSM_ST_RUN: begin
					// Go from host or a chained slot 40 jumps
					if (cmd_valid && cmd_op == `SSM_OP_GO &&
						ok_run(cmd_slot) && used_q[cmd_slot]) begin // R14
						run_slot <= cmd_slot;
						run_paused <= 1'b0;
						ptr_q <= start_q[cmd_slot];
						end_q <= start_q[cmd_slot] + len_q[cmd_slot];
						play_chain <= 1'b1; // R18
					end else if (!play_valid || play_ready) begin
						play_chain <= 1'b0;
						if (ptr_q == end_q) begin
							st_q <= `SSM_ST_IDLE;
							busy <= 1'b0;
							play_valid <= 1'b0;
						end else begin
							play_data <= mem_q[ptr_q]; // R3
							play_valid <= 1'b1;
							ptr_q <= ptr_q + 11'h001;
						end
					end
				end
				`SSM_ST_SAVE: begin
					nv_dirty <= 1'b0; // R10
					st_q <= `SSM_ST_IDLE;
					busy <= 1'b0;
				end
				default: st_q <= `SSM_ST_IDLE;
				endcase
			end
		end
	end
endmodule // ssm_top
`default_nettype wire

// file: ssm_top_chk.sv
// Purpose: port assertions for ssm_top
// Assumes: commands judged only while idle
// Notes:   error pulse may lag one cycle
`default_nettype none
`include "ssm_map.vh"
module ssm_chk (
	// Clock, reset, command
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic       cmd_valid,
	input wire logic [3:0] cmd_op,
	input wire logic [5:0] cmd_slot,
	input wire logic       cmd_flag,
	// Results
	input wire logic       play_ready,
	input wire logic       play_valid,
	input wire logic [7:0] play_data,
	input wire logic       run_paused,
	input wire logic       irq_run_mode,
	input wire logic       busy,
	input wire logic       cmd_error,
	input wire logic       nv_dirty
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Idle command and zero slot helpers
	wire logic t = cmd_valid && !busy;
	wire logic z = cmd_slot == 6'h00;
	property p_def; t && cmd_op == `SSM_OP_DEFINE && (z || cmd_slot > 6'h28)
		|-> ##[1:2] cmd_error; endproperty
	a_def: assert property (p_def) else $error("define slot");
	property p_run; t && cmd_op == `SSM_OP_RUN && (z || cmd_slot > 6'h27)
		|-> ##[1:2] cmd_error; endproperty
	a_run: assert property (p_run) else $error("run slot");
	property p_era; t && cmd_op == `SSM_OP_ERASE && (z || cmd_slot > 6'h28)
		|-> ##[1:2] cmd_error; endproperty
	a_era: assert property (p_era) else $error("erase slot");
	property p_hold; play_valid && !play_ready
		|=> play_valid && $stable(play_data); endproperty
	a_hold: assert property (p_hold) else $error("byte dropped");
	property p_pau; $rose(run_paused) |-> $past(cmd_op) == `SSM_OP_RUNP
		|| $past(cmd_op, 2) == `SSM_OP_RUNP; endproperty
	a_pau: assert property (p_pau) else $error("pause cause");
	property p_irq; t && cmd_op == `SSM_OP_IRMODE
		|-> ##2 irq_run_mode == $past(cmd_flag, 2); endproperty
	a_irq: assert property (p_irq) else $error("run mode");
	property p_sav; t && cmd_op == `SSM_OP_SAVE |-> ##2 !nv_dirty;
		endproperty
	a_sav: assert property (p_sav) else $error("save");
	property p_boot; $rose(rst_b) |-> !busy [*2]; endproperty
	a_boot: assert property (p_boot) else $error("boot run");
endmodule // ssm_chk
bind ssm_top ssm_chk chk_u (.clk, .rst_b, .cmd_valid, .cmd_op, .cmd_slot,
	.cmd_flag, .play_ready, .play_valid, .play_data, .run_paused,
	.irq_run_mode, .busy, .cmd_error, .nv_dirty);
`default_nettype wire

// file: ssm_sink.sv
// Purpose: host-side sink of replayed bytes
// Assumes: byte taken where valid meets ready
// Notes:   slow mode stalls every other cycle
`default_nettype none
module ssm_sink (
	// Clock and replay port
	input wire logic       clk,
	input wire logic       slow,
	input wire logic       play_valid,
	input wire logic [7:0] play_data,
	output var logic       play_ready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got [$];
	// Toggling stall exercises the hold
	initial play_ready = 1'b0;
	always @(negedge clk) play_ready <= slow ? ~play_ready : 1'b1;
	// Bytes kept in arrival order
	always @(posedge clk) if (play_valid && play_ready) got.push_back(play_data);
endmodule // ssm_sink
`default_nettype wire

// file: stored_sequence_manager_test.sv
// Purpose: directed test of ssm_top
// Assumes: inputs change on falling edge
// Notes:   scan and jump paths use slots 1 and 2
`default_nettype none
`include "ssm_map.vh"
module stored_sequence_manager_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_b, cmd_valid, cmd_flag, chr_valid, chr_buffered, slow, e;
	logic play_ready, play_valid, play_chain, run_paused, irq_run_mode;
	logic busy, cmd_error, nv_dirty;
	logic [3:0] cmd_op, cmd_input_idx;
	logic [5:0] cmd_slot, run_slot;
	logic [7:0] chr_data, prog_in, play_data;
	int err_count, checks;
	ssm_top dut_u (.clk, .rst_b, .cmd_valid, .cmd_op, .cmd_slot, .cmd_flag,
		.cmd_input_idx, .chr_valid, .chr_data, .chr_buffered, .prog_in,
		.play_ready, .play_valid, .play_data, .play_chain, .run_slot,
		.run_paused, .irq_run_mode, .busy, .cmd_error, .nv_dirty);
	ssm_sink snk_u (.clk, .slow, .play_valid, .play_data, .play_ready);
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task chk(input logic [7:0] got, exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task stop_test;
		$display("errors=%0d checks=%0d", err_count, checks);
		if (err_count == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// One command, then gather any error pulse
	task cmd(input logic [3:0] op, input logic [5:0] s, input logic f);
		cmd_op = op;
		cmd_slot = s;
		cmd_flag = f;
		cmd_valid = 1'b1;
		@(negedge clk) cmd_valid = 1'b0;
		// Error pulse stands in the cycle right after the take edge
		e = cmd_error;
		repeat (3) @(negedge clk) e |= cmd_error;
	endtask
	task chr(input logic [7:0] d, input logic b);
		chr_data = d;
		chr_buffered = b;
		chr_valid = 1'b1;
		@(negedge clk) chr_valid = 1'b0;
	endtask
	// Bounded wait for a run to finish
	task wt;
		for (int i = 0; i < 60 && busy !== 1'b0; i++) @(negedge clk);
	endtask
	task t_def;
		chk(busy, 0);
		cmd(`SSM_OP_DEFINE, 6'h01, 0);
		chr(8'hA1, 1);
		chr(8'h55, 0);
		chr(8'hB2, 1);
		cmd(`SSM_OP_TERM, 6'h00, 0);
		chk(nv_dirty, 1);
		cmd(`SSM_OP_DEFINE, 6'h01, 0);
		chk(e, 1);
		slow = 1'b1;
		cmd(`SSM_OP_RUN, 6'h01, 0);
		wt;
		chk(snk_u.got.size(), 2);
		chk(snk_u.got[0], 8'hA1);
		chk(snk_u.got[1], 8'hB2);
		cmd(`SSM_OP_SAVE, 6'h00, 0);
		chk(nv_dirty, 0);
	endtask
	task t_bad;
		cmd(`SSM_OP_DEFINE, 6'h29, 0);
		chk(e, 1);
		cmd(`SSM_OP_RUN, 6'h28, 0);
		chk(e, 1);
		cmd(`SSM_OP_ERASE, 6'h29, 0);
		chk(e, 1);
	endtask
	task t_era;
		cmd(`SSM_OP_ERASE, 6'h01, 0);
		cmd(`SSM_OP_DEFINE, 6'h01, 0);
		chk(e, 0);
		chr(8'hC3, 1);
		cmd(`SSM_OP_TERM, 6'h00, 0);
		cmd(`SSM_OP_IRMODE, 6'h00, 1);
		chk(irq_run_mode, 1);
		cmd(`SSM_OP_RUNP, 6'h01, 0);
		chk(run_paused, 1);
		wt;
	endtask
	// Run slot 2, then jump to slot 1 one cycle later
	task t_go;
		cmd(`SSM_OP_DEFINE, 6'h02, 0);
		chr(8'h11, 1);
		chr(8'h22, 1);
		chr(8'h33, 1);
		chr(8'h44, 1);
		cmd(`SSM_OP_TERM, 6'h00, 0);
		cmd_op = `SSM_OP_RUN;
		cmd_slot = 6'h02;
		cmd_valid = 1'b1;
		@(negedge clk) cmd_op = `SSM_OP_GO;
		cmd_slot = 6'h01;
		@(negedge clk) cmd_valid = 1'b0;
		chk(play_chain, 1);
		chk(run_slot, 8'h01);
		wt;
	endtask
	// Only input 1 selects; pins 0x03 must pick slot 2, not 3
	task t_scan;
		cmd_input_idx = 4'h1;
		cmd(`SSM_OP_INFUNC, 6'h01, 1);
		cmd(`SSM_OP_SCAN, 6'h00, 1);
		prog_in = 8'h03;
		repeat (8) @(negedge clk);
		chk(run_slot, 8'h02);
		wt;
		chk(busy, 0);
	endtask
	// Main sequence: inputs quiet, reset, scenarios
	initial begin
		{cmd_valid, cmd_op, cmd_slot, cmd_flag, cmd_input_idx, chr_valid} = '0;
		{chr_data, chr_buffered, prog_in, slow, rst_b} = '0;
		repeat (8) @(negedge clk);
		rst_b = 1'b1;
		repeat (2) @(negedge clk);
		t_def;
		t_bad;
		t_era;
		t_go;
		t_scan;
		stop_test;
	end
	// Watchdog well beyond the expected run
	initial begin
		#200000;
		err_count++;
		stop_test;
	end
endmodule // stored_sequence_manager_test
`default_nettype wire
